// ---- inc/lsw_pkg.sv ----
// Constants and types shared by the lane status and transmit switch registers
package lsw_pkg;
  // ====
  // Register offsets, device address 1E
  localparam logic [15:0] LSW_OFF_LANE2_CNT = 16'h0013;
  localparam logic [15:0] LSW_OFF_LANE3_CNT = 16'h0014;
  localparam logic [15:0] LSW_OFF_LS_STATUS = 16'h0015;
  localparam logic [15:0] LSW_OFF_HS_ROT = 16'h0016;
  localparam logic [15:0] LSW_OFF_TX_CTRL = 16'h0017;
  // ====
  // Reset values
  localparam logic [15:0] LSW_RST_LANE2_CNT = 16'h0000;
  localparam logic [15:0] LSW_RST_LANE3_CNT = 16'hFFFD;
  localparam logic [15:0] LSW_RST_TX_CTRL = 16'h2000;
  localparam logic [15:0] LSW_CNT_CLEARED = 16'h0000;
  localparam logic [7:0] LSW_RST_FILL_CYCLES = 8'h20;
  // ====
  // Status field positions
  localparam int LSW_ST_BAD_CODE = 11;
  localparam int LSW_ST_LOS = 10;
  localparam int LSW_ST_FIFO = 9;
  localparam int LSW_ST_SYNC = 8;
  // ====
  // Transmit switch control field positions
  localparam int LSW_TC_PIN_EN = 12;
  localparam int LSW_TC_SRC1_LSB = 10;
  localparam int LSW_TC_SRC0_LSB = 8;
  localparam int LSW_TC_OFF = 7;
  localparam int LSW_TC_ON = 6;
  localparam int LSW_TC_FILL = 5;
  // ====
  // Operating modes
  localparam logic [1:0] LSW_MODE_10GKR = 2'h0;
  localparam logic [1:0] LSW_MODE_10G = 2'h1;
  localparam logic [1:0] LSW_MODE_1GKX = 2'h2;
  // Source codes
  localparam logic [1:0] LSW_SRC_LS = 2'h0;
  localparam logic [1:0] LSW_SRC_HS = 2'h1;
  // ====
  // Trigger kinds and fill words
  typedef enum logic [2:0] {
    LSW_TRIG_NONE,
    LSW_TRIG_LOCAL_FAULT,
    LSW_TRIG_IDLE_ALL,
    LSW_TRIG_SYMBOL,
    LSW_TRIG_IDLE_SET
  } lsw_trig_type;
  localparam logic [31:0] LSW_WORD_LOCAL_FAULT = 32'h0100_009C;
  localparam logic [31:0] LSW_WORD_IDLE_KR = 32'h0707_0707;
  localparam logic [31:0] LSW_WORD_ERR_KX = 32'hFEFE_FEFE;
  localparam logic [31:0] LSW_WORD_IDLE_KX = 32'h50BC_50BC;
  localparam logic [31:0] LSW_WORD_NONE = 32'h0000_0000;
  // Fill sequencer states
  typedef enum logic {
    LSW_FILL_IDLE,
    LSW_FILL_BUSY
  } lsw_fill_type;
endpackage : lsw_pkg

// ---- logic/lsw_err_tally.sv ----
// Clear-on-read 16-bit code error counter for one low-speed lane
`timescale 1ns/1ps
`default_nettype none
module lsw_err_tally #(
  parameter int WIDTH = 16,
  parameter logic [15:0] RESET_VALUE = lsw_pkg::LSW_RST_LANE2_CNT
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic count_i,
  input wire logic clear_i,
  output logic [WIDTH-1:0] value_o
);
  logic [WIDTH-1:0] tally_r;
  logic [WIDTH-1:0] tally_nxt;
  wire logic [WIDTH-1:0] base = clear_i ? WIDTH'(lsw_pkg::LSW_CNT_CLEARED) : tally_r;
  wire logic at_max = &tally_r;

  // Event in the clearing cycle counts as the first of the next window
  assign tally_nxt = (count_i && !(at_max && !clear_i)) ? base + WIDTH'(1) : base;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tally_r <= WIDTH'(RESET_VALUE);
    end else if (ce_i) begin
      tally_r <= tally_nxt;
    end
  end

  assign value_o = tally_r;
endmodule : lsw_err_tally
`default_nettype wire

// ---- logic/lsw_regs.sv ----
// Lane error counters, lane status and first transmit switch control registers
//
// Operation
// - 10GKR/1GKX: counters tally decoder invalid codes.
// - 10G: counters tally alignment-slave decoder invalid codes.
// - Low-speed test verification: counters tally pattern errors.
// - Counter read returns value, then clears to zero.
// - Status bit 11 latches bad code of selected lane.
// - Status bit 10 latches signal loss of selected lane.
// - Status bit 9 latches alignment FIFO error.
// - Status bit 8 shows selected lane sync, holding loss until read.
// - Status bits 3:0 show slow sync pointer.
// - 10GKR: fast status 6:0 is seven-bit rotation.
// - 10G/1GKX: bits 6:4 sync state, 3:0 rotation.
// - Control bit 12 hands source to reused address pin.
// - Control bit 12 clear, the default: software picks source.
// - Pin high: bits 11:10 pick source, 00 slow, 01 fast.
// - Pin low: bits 9:8 pick source, same encoding.
// - Bit 7 picks OFF trigger per KR or KX mode.
// - Bit 6 picks ON trigger per KR or KX mode.
// - Bit 5 picks fill pattern during a switch.
// - Trigger and fill choices act only in KR and KX.
// - Pin control off: software field picks source.
// - Switch masks output with fill for programmed cycles.
`timescale 1ns/1ps
`default_nettype none
module lsw_regs #(
  parameter int LANES = 4,
  parameter int CNT_WIDTH = 16
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Management register port
  input wire logic [15:0] mgmt_addr_i,
  input wire logic mgmt_rd_i,
  input wire logic mgmt_wr_i,
  input wire logic [15:0] mgmt_wdata_i,
  output logic [15:0] mgmt_rdata_o,
  output logic mgmt_rvalid_o,
  // Operating mode and low-speed test state
  input wire logic [1:0] op_mode_i,
  input wire logic ls_test_mode_i,
  // Per-lane error sources
  input wire logic [LANES-1:0] dec_err_i,
  input wire logic [LANES-1:0] align_dec_err_i,
  input wire logic [LANES-1:0] pattern_err_i,
  // Status sources
  input wire logic [1:0] status_lane_select_i,
  input wire logic [LANES-1:0] slow_side_signal_loss_i,
  input wire logic [LANES-1:0] slow_side_sync_i,
  input wire logic lane_deskew_fifo_fault_i,
  input wire logic [3:0] slow_side_sync_pointer_i,
  input wire logic [6:0] fast_side_sync_pointer_i,
  input wire logic [2:0] fast_side_sync_state_i,
  // Transmit switch controls
  input wire logic port_address_bit0_pin_i,
  input wire logic addr_pin_reuse_enable_i,
  input wire logic addr_pin_reuse_target_i,
  input wire logic [1:0] tx_software_source_choice_i,
  input wire logic [7:0] tx_fill_duration_i,
  output logic [1:0] tx_source_o,
  output logic tx_fill_active_o,
  output logic [31:0] tx_fill_word_o,
  output logic [2:0] tx_off_trigger_o,
  output logic [2:0] tx_on_trigger_o
);
  // ====
  // Decode
  wire logic rd_lane2 = mgmt_rd_i && (mgmt_addr_i == lsw_pkg::LSW_OFF_LANE2_CNT);
  wire logic rd_lane3 = mgmt_rd_i && (mgmt_addr_i == lsw_pkg::LSW_OFF_LANE3_CNT);
  wire logic rd_status = mgmt_rd_i && (mgmt_addr_i == lsw_pkg::LSW_OFF_LS_STATUS);
  wire logic wr_ctrl = mgmt_wr_i && (mgmt_addr_i == lsw_pkg::LSW_OFF_TX_CTRL);
  wire logic mode_kr = (op_mode_i == lsw_pkg::LSW_MODE_10GKR);
  wire logic mode_kx = (op_mode_i == lsw_pkg::LSW_MODE_1GKX);

  // ====
  // Error counters, lanes 2 and 3
  logic [LANES-1:0] lane_err;
  logic [CNT_WIDTH-1:0] lane2_error_tally;
  logic [CNT_WIDTH-1:0] lane3_error_tally;

  always_comb begin
    if (ls_test_mode_i) begin
      lane_err = pattern_err_i;
    end else if (op_mode_i == lsw_pkg::LSW_MODE_10G) begin
      lane_err = align_dec_err_i;
    end else begin
      lane_err = dec_err_i;
    end
  end

  lsw_err_tally #(
    .WIDTH(CNT_WIDTH),
    .RESET_VALUE(lsw_pkg::LSW_RST_LANE2_CNT)
  ) u_lane2_tally (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .count_i(lane_err[2]),
    .clear_i(rd_lane2),
    .value_o(lane2_error_tally)
  );

  lsw_err_tally #(
    .WIDTH(CNT_WIDTH),
    .RESET_VALUE(lsw_pkg::LSW_RST_LANE3_CNT)
  ) u_lane3_tally (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .count_i(lane_err[3]),
    .clear_i(rd_lane3),
    .value_o(lane3_error_tally)
  );

  // ====
  // Low-speed status latches
  logic bad_code_hold_r;
  logic los_hold_r;
  logic fifo_hold_r;
  logic sync_lost_hold_r;
  logic bad_code_hold_nxt;
  logic los_hold_nxt;
  logic fifo_hold_nxt;
  logic sync_lost_hold_nxt;

  wire logic sel_bad_code = dec_err_i[status_lane_select_i];
  wire logic sel_los = slow_side_signal_loss_i[status_lane_select_i];
  wire logic sel_sync = slow_side_sync_i[status_lane_select_i];

  // Hardware set wins over the read clear
  assign bad_code_hold_nxt = sel_bad_code | (bad_code_hold_r & ~rd_status);
  assign los_hold_nxt = sel_los | (los_hold_r & ~rd_status);
  assign fifo_hold_nxt = lane_deskew_fifo_fault_i | (fifo_hold_r & ~rd_status);
  assign sync_lost_hold_nxt = ~sel_sync | (sync_lost_hold_r & ~rd_status);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bad_code_hold_r <= 1'b0;
      los_hold_r <= 1'b0;
      fifo_hold_r <= 1'b0;
      sync_lost_hold_r <= 1'b0;
    end else if (ce_i) begin
      bad_code_hold_r <= bad_code_hold_nxt;
      los_hold_r <= los_hold_nxt;
      fifo_hold_r <= fifo_hold_nxt;
      sync_lost_hold_r <= sync_lost_hold_nxt;
    end
  end

  // Held value or live condition, whichever shows the event
  wire logic slow_side_bad_code_flag = bad_code_hold_r | sel_bad_code;
  wire logic slow_side_los_flag = los_hold_r | sel_los;
  wire logic fifo_flag = fifo_hold_r | lane_deskew_fifo_fault_i;
  wire logic slow_side_sync_flag = sel_sync & ~sync_lost_hold_r;

  logic [15:0] low_speed_lane_status;
  always_comb begin
    low_speed_lane_status = 16'h0000;
    low_speed_lane_status[lsw_pkg::LSW_ST_BAD_CODE] = slow_side_bad_code_flag;
    low_speed_lane_status[lsw_pkg::LSW_ST_LOS] = slow_side_los_flag;
    low_speed_lane_status[lsw_pkg::LSW_ST_FIFO] = fifo_flag;
    low_speed_lane_status[lsw_pkg::LSW_ST_SYNC] = slow_side_sync_flag;
    low_speed_lane_status[3:0] = slow_side_sync_pointer_i;
  end

  // ====
  // High-speed rotation view
  logic [15:0] high_speed_sync_rotation;
  always_comb begin
    high_speed_sync_rotation = 16'h0000;
    if (mode_kr) begin
      high_speed_sync_rotation[6:0] = fast_side_sync_pointer_i;
    end else begin
      high_speed_sync_rotation[6:4] = fast_side_sync_state_i;
      high_speed_sync_rotation[3:0] = fast_side_sync_pointer_i[3:0];
    end
  end

  // ====
  // Transmit switch control register
  logic [15:0] tx_switch_control_first_r;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_switch_control_first_r <= lsw_pkg::LSW_RST_TX_CTRL;
    end else if (ce_i && wr_ctrl) begin
      // Bits 15:13 stored as written; host keeps them at 001
      tx_switch_control_first_r <= mgmt_wdata_i;
    end
  end

  wire logic tx_switch_pin_control_on = tx_switch_control_first_r[lsw_pkg::LSW_TC_PIN_EN];
  wire logic [1:0] tx_source_when_pin_high =
    tx_switch_control_first_r[lsw_pkg::LSW_TC_SRC1_LSB +: 2];
  wire logic [1:0] tx_source_when_pin_low =
    tx_switch_control_first_r[lsw_pkg::LSW_TC_SRC0_LSB +: 2];
  wire logic tx_off_trigger_choice = tx_switch_control_first_r[lsw_pkg::LSW_TC_OFF];
  wire logic tx_on_trigger_choice = tx_switch_control_first_r[lsw_pkg::LSW_TC_ON];
  wire logic tx_fill_pattern_choice = tx_switch_control_first_r[lsw_pkg::LSW_TC_FILL];

  // ====
  // Address pin synchroniser and source selection
  logic pin_meta_r;
  logic pin_sync_r;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
    end else if (ce_i) begin
      pin_meta_r <= port_address_bit0_pin_i;
      pin_sync_r <= pin_meta_r;
    end
  end

  wire logic pin_owns_switch =
    tx_switch_pin_control_on && addr_pin_reuse_enable_i && addr_pin_reuse_target_i;
  wire logic [1:0] pin_source = pin_sync_r ? tx_source_when_pin_high
                                           : tx_source_when_pin_low;
  wire logic [1:0] source_nxt = pin_owns_switch ? pin_source
                                                : tx_software_source_choice_i;

  // ====
  // Trigger and fill pattern choices
  lsw_pkg::lsw_trig_type off_trig;
  lsw_pkg::lsw_trig_type on_trig;
  logic [31:0] fill_word;

  always_comb begin
    off_trig = lsw_pkg::LSW_TRIG_NONE;
    on_trig = lsw_pkg::LSW_TRIG_NONE;
    fill_word = lsw_pkg::LSW_WORD_NONE;
    if (mode_kr) begin
      off_trig = tx_off_trigger_choice ? lsw_pkg::LSW_TRIG_LOCAL_FAULT
                                       : lsw_pkg::LSW_TRIG_IDLE_ALL;
      on_trig = tx_on_trigger_choice ? lsw_pkg::LSW_TRIG_LOCAL_FAULT
                                     : lsw_pkg::LSW_TRIG_IDLE_ALL;
      fill_word = tx_fill_pattern_choice ? lsw_pkg::LSW_WORD_LOCAL_FAULT
                                         : lsw_pkg::LSW_WORD_IDLE_KR;
    end else if (mode_kx) begin
      off_trig = tx_off_trigger_choice ? lsw_pkg::LSW_TRIG_SYMBOL
                                       : lsw_pkg::LSW_TRIG_IDLE_SET;
      on_trig = tx_on_trigger_choice ? lsw_pkg::LSW_TRIG_SYMBOL
                                     : lsw_pkg::LSW_TRIG_IDLE_SET;
      fill_word = tx_fill_pattern_choice ? lsw_pkg::LSW_WORD_ERR_KX
                                         : lsw_pkg::LSW_WORD_IDLE_KX;
    end
    // Other modes leave all three inactive
  end

  // ====
  // Switch sequencer: mask output with fill word after a source change
  lsw_pkg::lsw_fill_type fill_state_r;
  lsw_pkg::lsw_fill_type fill_state_nxt;
  logic [7:0] fill_left_r;
  logic [7:0] fill_left_nxt;
  logic [1:0] tx_source_r;

  wire logic source_change = (source_nxt != tx_source_r);
  wire logic fill_enabled = (mode_kr || mode_kx) && (tx_fill_duration_i != 8'h00);

  always_comb begin
    fill_state_nxt = fill_state_r;
    fill_left_nxt = fill_left_r;
    case (fill_state_r)
      lsw_pkg::LSW_FILL_IDLE: begin
        if (source_change && fill_enabled) begin
          fill_state_nxt = lsw_pkg::LSW_FILL_BUSY;
          fill_left_nxt = tx_fill_duration_i;
        end
      end
      lsw_pkg::LSW_FILL_BUSY: begin
        if (source_change && fill_enabled) begin
          fill_left_nxt = tx_fill_duration_i;
        end else if (fill_left_r == 8'h01) begin
          fill_state_nxt = lsw_pkg::LSW_FILL_IDLE;
          fill_left_nxt = 8'h00;
        end else begin
          fill_left_nxt = fill_left_r - 8'h01;
        end
      end
      default: begin
        fill_state_nxt = lsw_pkg::LSW_FILL_IDLE;
        fill_left_nxt = 8'h00;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fill_state_r <= lsw_pkg::LSW_FILL_IDLE;
      fill_left_r <= 8'h00;
      tx_source_r <= lsw_pkg::LSW_SRC_LS;
      tx_fill_active_o <= 1'b0;
      tx_fill_word_o <= lsw_pkg::LSW_WORD_NONE;
      tx_off_trigger_o <= lsw_pkg::LSW_TRIG_NONE;
      tx_on_trigger_o <= lsw_pkg::LSW_TRIG_NONE;
    end else if (ce_i) begin
      fill_state_r <= fill_state_nxt;
      fill_left_r <= fill_left_nxt;
      tx_source_r <= source_nxt;
      tx_fill_active_o <= (fill_state_nxt == lsw_pkg::LSW_FILL_BUSY);
      tx_fill_word_o <= fill_word;
      tx_off_trigger_o <= off_trig;
      tx_on_trigger_o <= on_trig;
    end
  end

  assign tx_source_o = tx_source_r;

  // ====
  // Read data
  logic [15:0] read_mux;
  always_comb begin
    case (mgmt_addr_i)
      lsw_pkg::LSW_OFF_LANE2_CNT: read_mux = lane2_error_tally;
      lsw_pkg::LSW_OFF_LANE3_CNT: read_mux = lane3_error_tally;
      lsw_pkg::LSW_OFF_LS_STATUS: read_mux = low_speed_lane_status;
      lsw_pkg::LSW_OFF_HS_ROT: read_mux = high_speed_sync_rotation;
      lsw_pkg::LSW_OFF_TX_CTRL: read_mux = tx_switch_control_first_r;
      default: read_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mgmt_rdata_o <= 16'h0000;
      mgmt_rvalid_o <= 1'b0;
    end else if (ce_i) begin
      mgmt_rvalid_o <= mgmt_rd_i;
      if (mgmt_rd_i) begin
        mgmt_rdata_o <= read_mux;
      end
    end
  end
endmodule : lsw_regs
`default_nettype wire

// ---- dv/lsw_regs_asserts.sv ----
// Port checks for the lane status and transmit switch registers
`timescale 1ns/1ps
`default_nettype none
module lsw_regs_asserts #(
  parameter int LANES = 4,
  parameter int CNT_WIDTH = 16
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [15:0] mgmt_addr_i,
  input wire logic mgmt_rd_i,
  input wire logic [15:0] mgmt_rdata_o,
  input wire logic mgmt_rvalid_o,
  input wire logic [1:0] op_mode_i,
  input wire logic [LANES-1:0] dec_err_i,
  input wire logic [LANES-1:0] align_dec_err_i,
  input wire logic [LANES-1:0] pattern_err_i,
  input wire logic [1:0] status_lane_select_i,
  input wire logic [LANES-1:0] slow_side_signal_loss_i,
  input wire logic [LANES-1:0] slow_side_sync_i,
  input wire logic lane_deskew_fifo_fault_i,
  input wire logic [3:0] slow_side_sync_pointer_i,
  input wire logic [6:0] fast_side_sync_pointer_i,
  input wire logic [2:0] fast_side_sync_state_i,
  input wire logic addr_pin_reuse_enable_i,
  input wire logic [1:0] tx_software_source_choice_i,
  input wire logic [1:0] tx_source_o,
  input wire logic tx_fill_active_o,
  input wire logic [31:0] tx_fill_word_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  wire rd_take = ce_i && mgmt_rd_i;
  wire rd_st = rd_take && (mgmt_addr_i == lsw_pkg::LSW_OFF_LS_STATUS);
  wire rd_hs = rd_take && (mgmt_addr_i == lsw_pkg::LSW_OFF_HS_ROT);
  wire rd_l3 = rd_take && (mgmt_addr_i == lsw_pkg::LSW_OFF_LANE3_CNT);
  wire quiet3 = !dec_err_i[3] && !align_dec_err_i[3] && !pattern_err_i[3];
  wire is_kr = (op_mode_i == lsw_pkg::LSW_MODE_10GKR);
  wire is_kx = (op_mode_i == lsw_pkg::LSW_MODE_1GKX);
  wire [3:0] fast_lo = fast_side_sync_pointer_i[3:0];
  // ====
  // Register port
  chk_read_answers:
    assert property (rd_take |=> mgmt_rvalid_o) else $error("read not answered");
  chk_answer_cause:
    assert property (mgmt_rvalid_o |-> $past(rd_take)) else $error("answer without read");
  chk_count_cleared:
    assert property (rd_l3 && quiet3 ##1 (quiet3 && !rd_take)[*2] ##1 rd_l3
      |=> mgmt_rdata_o == lsw_pkg::LSW_CNT_CLEARED)
    else $error("counter not cleared by read");
  // ====
  // Status latches, slow sync pointer and fast rotation
  chk_bad_code_held:
    assert property (ce_i && dec_err_i[status_lane_select_i] ##1 !rd_st ##1 rd_st
      && $stable(status_lane_select_i) |=> mgmt_rdata_o[11]) else $error("bad code lost");
  chk_los_held:
    assert property (ce_i && slow_side_signal_loss_i[status_lane_select_i] ##1 !rd_st ##1 rd_st
      && $stable(status_lane_select_i) |=> mgmt_rdata_o[10]) else $error("loss not held");
  chk_fifo_held:
    assert property (ce_i && lane_deskew_fifo_fault_i ##1 !rd_st ##1 rd_st |=> mgmt_rdata_o[9])
    else $error("fifo fault not held");
  chk_sync_loss_held:
    assert property (ce_i && !slow_side_sync_i[status_lane_select_i] ##1 !rd_st ##1 rd_st
      && $stable(status_lane_select_i) |=> !mgmt_rdata_o[8]) else $error("sync loss lost");
  chk_sync_pointer:
    assert property (rd_st |=> mgmt_rdata_o[3:0] == $past(slow_side_sync_pointer_i))
    else $error("slow pointer wrong");
  chk_fast_kr:
    assert property (rd_hs && is_kr |=> mgmt_rdata_o[6:0] == $past(fast_side_sync_pointer_i))
    else $error("kr rotation wrong");
  chk_fast_other:
    assert property (rd_hs && !is_kr |=> mgmt_rdata_o[6:4] == $past(fast_side_sync_state_i)
      && mgmt_rdata_o[3:0] == $past(fast_lo)) else $error("fast state wrong");
  // ====
  // Transmit switch
  chk_sw_source:
    assert property (ce_i && !addr_pin_reuse_enable_i |=>
      tx_source_o == $past(tx_software_source_choice_i)) else $error("software source wrong");
  chk_fill_off_mode:
    assert property (ce_i && !is_kr && !is_kx |=> tx_fill_word_o == lsw_pkg::LSW_WORD_NONE)
    else $error("fill word outside kr kx");
  cov_clear_read: cover property (rd_l3 ##1 mgmt_rvalid_o);
  cov_fill_start: cover property ($rose(tx_fill_active_o));
  cov_fast_source: cover property (tx_source_o == lsw_pkg::LSW_SRC_HS);
endmodule : lsw_regs_asserts
bind lsw_regs lsw_regs_asserts #(.LANES(LANES), .CNT_WIDTH(CNT_WIDTH)) u_lsw_chk (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .mgmt_addr_i(mgmt_addr_i),
  .mgmt_rd_i(mgmt_rd_i), .mgmt_rdata_o(mgmt_rdata_o), .mgmt_rvalid_o(mgmt_rvalid_o),
  .op_mode_i(op_mode_i), .dec_err_i(dec_err_i), .align_dec_err_i(align_dec_err_i),
  .pattern_err_i(pattern_err_i), .status_lane_select_i(status_lane_select_i),
  .slow_side_signal_loss_i(slow_side_signal_loss_i), .slow_side_sync_i(slow_side_sync_i),
  .lane_deskew_fifo_fault_i(lane_deskew_fifo_fault_i),
  .slow_side_sync_pointer_i(slow_side_sync_pointer_i),
  .fast_side_sync_pointer_i(fast_side_sync_pointer_i),
  .fast_side_sync_state_i(fast_side_sync_state_i),
  .addr_pin_reuse_enable_i(addr_pin_reuse_enable_i),
  .tx_software_source_choice_i(tx_software_source_choice_i), .tx_source_o(tx_source_o),
  .tx_fill_active_o(tx_fill_active_o), .tx_fill_word_o(tx_fill_word_o)
);
`default_nettype wire

// ---- dv/lsw_host_model.sv ----
// Management host model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module lsw_host_model (
  input wire logic mclk_i,
  input wire logic [15:0] rdata_i,
  input wire logic rvalid_i,
  output logic [15:0] addr_o,
  output logic rd_o,
  output logic wr_o,
  output logic [15:0] wdata_o
);
  initial begin
    addr_o = 16'h0000;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = 16'h0000;
  end
  task automatic write_reg(input logic [15:0] addr, input logic [15:0] data);
    @(posedge mclk_i);
    addr_o <= addr;
    wdata_o <= {3'b001, data[12:0]};
    wr_o <= 1'b1;
    @(posedge mclk_i);
    wr_o <= 1'b0;
  endtask : write_reg
  task automatic read_reg(input logic [15:0] addr, output logic [15:0] data, output logic ok);
    int n;
    ok = 1'b0;
    data = 16'h0000;
    @(posedge mclk_i);
    addr_o <= addr;
    rd_o <= 1'b1;
    @(posedge mclk_i);
    rd_o <= 1'b0;
    for (n = 0; n < 8 && !ok; n++) begin
      @(posedge mclk_i);
      if (rvalid_i === 1'b1) begin
        ok = 1'b1;
        data = rdata_i;
      end
    end
  endtask : read_reg
endmodule : lsw_host_model
`default_nettype wire

// ---- dv/lsw_regs_tb_top.sv ----
// Self-checking bench for the lane status and transmit switch registers
`timescale 1ns/1ps
`default_nettype none
module lsw_regs_tb_top;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce = 1'b1, rd, wr, rvalid, ls_test = 1'b0, fifo_err = 1'b0, fill_act;
  logic pin = 1'b0, reuse_en = 1'b0, reuse_tgt = 1'b0;
  logic [15:0] addr, wdata, rdata;
  logic [1:0] op_mode = 2'h0, lane_sel = 2'h0, sw_src = 2'h0, tx_src;
  logic [3:0] dec_err = 4'h0, align_err = 4'h0, pat_err = 4'h0, los = 4'h0, sync = 4'hF;
  logic [3:0] ls_ptr = 4'h0;
  logic [6:0] hs_ptr = 7'h00;
  logic [2:0] hs_state = 3'h0, off_trig, on_trig;
  logic [7:0] fill_len = 8'h20;
  logic [31:0] fill_word;
  logic [1:0] cmode [4] = '{2'h0, 2'h2, 2'h1, 2'h0};
  int csrc [4] = '{0, 0, 1, 2};
  int fail_count = 0;
  int cmp_count = 0;
  always #12.5 mclk_i = ~mclk_i;
  lsw_host_model host (.mclk_i(mclk_i), .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(addr),
    .rd_o(rd), .wr_o(wr), .wdata_o(wdata));
  lsw_regs uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce), .mgmt_addr_i(addr),
    .mgmt_rd_i(rd), .mgmt_wr_i(wr), .mgmt_wdata_i(wdata), .mgmt_rdata_o(rdata),
    .mgmt_rvalid_o(rvalid), .op_mode_i(op_mode), .ls_test_mode_i(ls_test),
    .dec_err_i(dec_err), .align_dec_err_i(align_err), .pattern_err_i(pat_err),
    .status_lane_select_i(lane_sel), .slow_side_signal_loss_i(los), .slow_side_sync_i(sync),
    .lane_deskew_fifo_fault_i(fifo_err), .slow_side_sync_pointer_i(ls_ptr),
    .fast_side_sync_pointer_i(hs_ptr), .fast_side_sync_state_i(hs_state),
    .port_address_bit0_pin_i(pin), .addr_pin_reuse_enable_i(reuse_en),
    .addr_pin_reuse_target_i(reuse_tgt), .tx_software_source_choice_i(sw_src),
    .tx_fill_duration_i(fill_len), .tx_source_o(tx_src), .tx_fill_active_o(fill_act),
    .tx_fill_word_o(fill_word), .tx_off_trigger_o(off_trig), .tx_on_trigger_o(on_trig));
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp, input string what);
    chk_out(32'(got), 32'(exp), what);
  endtask : chk_reg
  task automatic chk_out(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_out
  task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    host.read_reg(a, d, ok);
    if (!ok) begin
      fail_count++;
      $display("unexpected at %0t: no read answer", $time);
      give_verdict();
    end else begin
      chk_reg(d, exp, $sformatf("read %h", a));
    end
  endtask : rd_chk
  task automatic burst(input int src, input logic [3:0] lanes, input int n);
    @(posedge mclk_i);
    case (src)
      0: dec_err <= lanes;
      1: align_err <= lanes;
      default: pat_err <= lanes;
    endcase
    repeat (n) @(posedge mclk_i);
    dec_err <= 4'h0;
    align_err <= 4'h0;
    pat_err <= 4'h0;
  endtask : burst
  task automatic fill_cycles(output int n);
    int i;
    n = 0;
    for (i = 0; i < 300; i++) begin
      @(posedge mclk_i);
      if (fill_act === 1'b1) n++;
      else if (n > 0) break;
    end
  endtask : fill_cycles
  function automatic logic [2:0] exp_trig(input logic [1:0] m, input logic b);
    if (m == 2'h0) return b ? lsw_pkg::LSW_TRIG_LOCAL_FAULT : lsw_pkg::LSW_TRIG_IDLE_ALL;
    if (m == 2'h2) return b ? lsw_pkg::LSW_TRIG_SYMBOL : lsw_pkg::LSW_TRIG_IDLE_SET;
    return lsw_pkg::LSW_TRIG_NONE;
  endfunction : exp_trig
  function automatic logic [31:0] exp_fill(input logic [1:0] m, input logic b);
    if (m == 2'h0) return b ? lsw_pkg::LSW_WORD_LOCAL_FAULT : lsw_pkg::LSW_WORD_IDLE_KR;
    if (m == 2'h2) return b ? lsw_pkg::LSW_WORD_ERR_KX : lsw_pkg::LSW_WORD_IDLE_KX;
    return lsw_pkg::LSW_WORD_NONE;
  endfunction : exp_fill
  initial begin
    int i;
    int n;
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rd_chk(16'h0013, 16'h0000);
    rd_chk(16'h0014, 16'hFFFD);
    rd_chk(16'h0014, 16'h0000);
    rd_chk(16'h0017, 16'h2000);
    rd_chk(16'h001F, 16'h0000);
    $display("reset values done");
    for (i = 0; i < 4; i++) begin
      @(posedge mclk_i);
      op_mode <= cmode[i];
      ls_test <= (i == 3);
      burst(csrc[i], 4'hC, 3);
      burst((csrc[i] == 0) ? 1 : 0, 4'hC, 2);
      rd_chk(16'h0013, 16'h0003);
      rd_chk(16'h0014, 16'h0003);
    end
    $display("error counters done");
    @(posedge mclk_i);
    op_mode <= 2'h0;
    ls_test <= 1'b0;
    lane_sel <= 2'h1;
    ls_ptr <= 4'hA;
    @(posedge mclk_i);
    los <= 4'h4;
    dec_err <= 4'h4;
    sync <= 4'hB;
    @(posedge mclk_i);
    los <= 4'h0;
    dec_err <= 4'h0;
    sync <= 4'hF;
    rd_chk(16'h0015, 16'h010A);
    @(posedge mclk_i);
    los <= 4'h2;
    dec_err <= 4'h2;
    sync <= 4'hD;
    fifo_err <= 1'b1;
    @(posedge mclk_i);
    los <= 4'h0;
    dec_err <= 4'h0;
    sync <= 4'hF;
    fifo_err <= 1'b0;
    rd_chk(16'h0015, 16'h0E0A);
    rd_chk(16'h0015, 16'h010A);
    $display("lane status done");
    hs_ptr <= 7'h5B;
    hs_state <= 3'h6;
    host.write_reg(16'h0016, 16'hFFFF);
    for (i = 0; i < 3; i++) begin
      @(posedge mclk_i);
      op_mode <= 2'(i);
      rd_chk(16'h0016, (i == 0) ? 16'h005B : 16'h006B);
    end
    $display("fast rotation done");
    @(posedge mclk_i);
    op_mode <= 2'h0;
    sw_src <= 2'h1;
    fill_cycles(n);
    chk_out(32'(n), 32'h0000_0020, "fill length");
    chk_out(32'(tx_src), 32'h0000_0001, "software source");
    fill_len <= 8'h03;
    reuse_en <= 1'b1;
    reuse_tgt <= 1'b1;
    pin <= 1'b1;
    sw_src <= 2'h0;
    host.write_reg(16'h0017, 16'h3400);
    rd_chk(16'h0017, 16'h3400);
    repeat (6) @(posedge mclk_i);
    chk_out(32'(tx_src), 32'h0000_0001, "pin high source");
    pin <= 1'b0;
    host.write_reg(16'h0017, 16'h3100);
    repeat (6) @(posedge mclk_i);
    chk_out(32'(tx_src), 32'h0000_0001, "pin low source");
    reuse_en <= 1'b0;
    repeat (6) @(posedge mclk_i);
    chk_out(32'(tx_src), 32'h0000_0000, "pin not enabled");
    reuse_en <= 1'b1;
    host.write_reg(16'h0017, 16'h2100);
    repeat (6) @(posedge mclk_i);
    chk_out(32'(tx_src), 32'h0000_0000, "pin control off");
    $display("source selection done");
    for (i = 0; i < 6; i++) begin
      @(posedge mclk_i);
      op_mode <= cmode[i % 3];
      host.write_reg(16'h0017, (i < 3) ? 16'h20A0 : 16'h2040);
      repeat (2) @(posedge mclk_i);
      chk_out(32'(off_trig), 32'(exp_trig(op_mode, i < 3)), "off");
      chk_out(32'(on_trig), 32'(exp_trig(op_mode, i >= 3)), "on");
      chk_out(fill_word, exp_fill(op_mode, i < 3), "fill word");
    end
    $display("trigger selection done");
    give_verdict();
  end
endmodule : lsw_regs_tb_top
`default_nettype wire
